// File: design/sppin_pkg.sv
// package for the serial port pin and strap block
package sppin_pkg;

  // bit positions: configuration register bits fed by straps, then handshake status and gpio port 1 bits
  localparam int CFG_ADDR_BIT = 6;    // global_config_reg_26 bit
  localparam int FLOPPY_UART_BIT = 1;   // global_config_reg_24 bit
  localparam int KEYBOARD_EN_BIT = 2;   // global_config_reg_24 bit
  localparam int MSR_CTS_BIT = 4;     // handshake status bit for cts
  localparam int MSR_DSR_BIT = 5;
  localparam int MSR_DCD_BIT = 7;
  localparam int GP1_CTS_BIT = 7;     // cts of channel b on gpio port 1

  // config port addresses picked by the address strap
  localparam logic [7:0] CFG_PORT_LO = 8'h2e;
  localparam logic [7:0] CFG_PORT_HI = 8'h4e;

  // reset values of the strap-backed registers
  localparam logic [7:0] CFG_REG_26_RST = 8'h00;
  localparam logic [7:0] CFG_REG_24_RST = 8'h00;

  // fan drive duty in percent
  localparam logic [6:0] FAN_HALF = 7'h32;  // 50 percent
  localparam logic [6:0] FAN_FULL = 7'h64;  // 100 percent

  // strap pin group
  typedef struct packed {
    logic cfg_port;    // config_port_select_strap
    logic floppy_uart;    // floppy_or_uart_strap
    logic keyboard_en;    // keyboard_ctrl_enable_strap
    logic fan_full;    // fan speed strap
    logic pin_func;    // shared_pin_function_strap
  } sppin_strap_t;

  // modem side inputs of one channel
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic sin;
  } sppin_mdm_in_t;

  // uart core side outputs of one channel
  typedef struct packed {
    logic rts;     // active high, core wants to send
    logic dtr;     // active high, core ready
    logic sout;
  } sppin_core_out_t;

endpackage

// File: design/sppin_top.sv
// serial port pins, gpio alternates and power-on straps
`timescale 1ns/1ps
//
// Summary of operation
// [RULE_01] cts level readable at handshake status bit 4
// [RULE_02] data set ready input is active low
// [RULE_03] request to send driven low when ready
// [RULE_04] terminal ready driven low when ready
// [RULE_05] carrier detect input is active low
// [RULE_06] serial input pin feeds channel receiver
// [RULE_07] channel transmitter drives serial output pin
// [RULE_08] address strap sets config bit 6
// [RULE_09] floppy/uart strap sets config bit 1
// [RULE_10] keyboard enable strap sets config bit 2
// [RULE_11] fan strap picks 50 or 100 percent
// [RULE_12] function strap picks beep/led or gpio
// [RULE_13] channel b pins switchable to gpio port 1
// [RULE_14] straps latched once at reset release
module sppin_top #(
  parameter int NCH = 6
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire sppin_pkg::sppin_strap_t strap_i,
  input wire sppin_pkg::sppin_mdm_in_t [NCH-1:0] mdm_i,
  input wire sppin_pkg::sppin_core_out_t [NCH-1:0] core_i,
  input wire logic infrared_receive_in_i,
  input wire logic ir_sel_i,
  input wire logic ir_tx_i,
  input wire logic gp1_sel_i,
  input wire logic [7:0] gp1_out_i,
  input wire logic [7:0] gp1_oe_n_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_reg_26_wdata_i,
  input wire logic [7:0] cfg_reg_24_wdata_i,
  input wire logic beep_i,
  input wire logic led_i,
  input wire logic [1:0] gpo_i,
  output logic [NCH-1:0][7:0] hs_status_o,
  output logic [NCH-1:0] core_sin_o,
  output logic [NCH-1:0] request_send_n_o,
  output logic [NCH-1:0] terminal_ready_n_o,
  output logic [NCH-1:0] serial_out_o,
  output logic infrared_transmit_out_o,
  output logic [7:0] gp1_in_o,
  output logic [7:0] gp1_pin_oe_n_o,
  output logic [7:0] global_config_reg_26_o,
  output logic [7:0] global_config_reg_24_o,
  output logic [7:0] cfg_port_o,
  output logic [6:0] fan_duty_o,
  output logic [1:0] shared_pin_o
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: every pin passes two flops
  sppin_pkg::sppin_mdm_in_t [NCH-1:0] mdm_s1_r, mdm_s2_r;
  sppin_pkg::sppin_strap_t strap_s1_r, strap_s2_r;
  logic ir_rx_s1_r, ir_rx_s2_r;

  // pins carry no reset so a strap is never forced by the reset itself
  always_ff @(posedge clk_sys_i) begin
    mdm_s1_r <= mdm_i;
    mdm_s2_r <= mdm_s1_r;
    strap_s1_r <= strap_i;
    strap_s2_r <= strap_s1_r;
    ir_rx_s1_r <= infrared_receive_in_i;
    ir_rx_s2_r <= ir_rx_s1_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture
  logic in_reset_r;
  logic [7:0] cfg_reg_26_r, cfg_reg_24_r;
  logic fan_full_r, pin_func_r;
  wire strap_take = in_reset_r && resetn_i;  // first cycle after release

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  // [RULE_14] one-shot latch at release
  // capture happens once after release, so a strap that moves later is
  // ignored; software may overwrite the configuration copy afterwards
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cfg_reg_26_r <= sppin_pkg::CFG_REG_26_RST;
      cfg_reg_24_r <= sppin_pkg::CFG_REG_24_RST;
      fan_full_r <= 1'b0;
      pin_func_r <= 1'b0;
    end else if (strap_take) begin
      // [RULE_08] address strap to bit 6
      cfg_reg_26_r[sppin_pkg::CFG_ADDR_BIT] <= strap_s2_r.cfg_port;
      // [RULE_09] floppy or uart select
      cfg_reg_24_r[sppin_pkg::FLOPPY_UART_BIT] <= strap_s2_r.floppy_uart;
      // [RULE_10] keyboard controller enable
      cfg_reg_24_r[sppin_pkg::KEYBOARD_EN_BIT] <= strap_s2_r.keyboard_en;
      // [RULE_11] fan speed strap
      fan_full_r <= strap_s2_r.fan_full;
      // [RULE_12] shared pin function strap
      pin_func_r <= strap_s2_r.pin_func;
    end else if (cfg_wr_i) begin
      cfg_reg_26_r <= cfg_reg_26_wdata_i;
      cfg_reg_24_r <= cfg_reg_24_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel pin muxing, channel index 1 is uart b, index 0 uart a
  logic [NCH-1:0][7:0] hs_nxt;
  logic [NCH-1:0] rts_n_nxt, dtr_n_nxt, sout_nxt, sin_nxt;
  wire ir_on = ir_sel_i;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      hs_nxt[c] = 8'h00;
      // [RULE_01] cts level to status bit 4
      hs_nxt[c][sppin_pkg::MSR_CTS_BIT] = ~mdm_s2_r[c].cts_n;
      // [RULE_02] low dsr means ready
      hs_nxt[c][sppin_pkg::MSR_DSR_BIT] = ~mdm_s2_r[c].dsr_n;
      // [RULE_05] low dcd means carrier
      hs_nxt[c][sppin_pkg::MSR_DCD_BIT] = ~mdm_s2_r[c].dcd_n;
      // [RULE_03] rts low when ready to send
      rts_n_nxt[c] = ~core_i[c].rts;
      // [RULE_04] dtr low when ready
      dtr_n_nxt[c] = ~core_i[c].dtr;
      // [RULE_07] transmitter to output pin
      sout_nxt[c] = core_i[c].sout;
      // [RULE_06] input pin to receiver
      sin_nxt[c] = mdm_s2_r[c].sin;
    end
    // ir alternate takes over the channel b receive input unless gpio borrows the pins; ir transmit has its own output
    if (ir_on) begin
      sin_nxt[1] = ir_rx_s2_r;
    end
    // [RULE_13] channel b pins become gpio
    if (gp1_sel_i) begin
      hs_nxt[1] = 8'h00;
      sin_nxt[1] = 1'b1;  // idle mark level while borrowed
      rts_n_nxt[1] = gp1_out_i[5];
      dtr_n_nxt[1] = gp1_out_i[4];
      sout_nxt[1] = gp1_out_i[2];
    end
  end

  // gpio port 1 input view of channel b pins
  wire [7:0] gp1_in_nxt = {mdm_s2_r[1].cts_n, mdm_s2_r[1].dsr_n,
                           gp1_out_i[5], gp1_out_i[4], mdm_s2_r[1].sin,
                           gp1_out_i[2], mdm_s2_r[1].dcd_n, 1'b1};
  // bits 5,4,2 are the outputs; inputs never drive
  wire [7:0] gp1_oe_nxt = gp1_sel_i ? (gp1_oe_n_i | 8'hcb) : 8'hff;

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      hs_status_o <= '0;
      core_sin_o <= '1;
      request_send_n_o <= '1;
      terminal_ready_n_o <= '1;
      serial_out_o <= '1;
      infrared_transmit_out_o <= 1'b0;
      gp1_in_o <= 8'hff;
      gp1_pin_oe_n_o <= 8'hff;
      shared_pin_o <= 2'h0;
    end else begin
      hs_status_o <= hs_nxt;
      core_sin_o <= sin_nxt;
      request_send_n_o <= rts_n_nxt;
      terminal_ready_n_o <= dtr_n_nxt;
      serial_out_o <= sout_nxt;
      infrared_transmit_out_o <= ir_on & ir_tx_i;
      gp1_in_o <= gp1_in_nxt;
      gp1_pin_oe_n_o <= gp1_oe_nxt;
      // [RULE_12] beep/led or gpio output
      shared_pin_o <= pin_func_r ? gpo_i : {led_i, beep_i};
    end
  end

  // configuration views
  assign global_config_reg_26_o = cfg_reg_26_r;
  assign global_config_reg_24_o = cfg_reg_24_r;
  wire cfg_addr_bit = cfg_reg_26_r[sppin_pkg::CFG_ADDR_BIT];

  // [RULE_08] port address from bit 6
  logic [7:0] cfg_port_r;
  logic [6:0] fan_duty_r;
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cfg_port_r <= sppin_pkg::CFG_PORT_LO;
      fan_duty_r <= sppin_pkg::FAN_HALF;
    end else begin
      cfg_port_r <= cfg_addr_bit ?
                    sppin_pkg::CFG_PORT_HI : sppin_pkg::CFG_PORT_LO;
      // [RULE_11] fan duty from latched strap
      fan_duty_r <= fan_full_r ? sppin_pkg::FAN_FULL : sppin_pkg::FAN_HALF;
    end
  end
  assign cfg_port_o = cfg_port_r;
  assign fan_duty_o = fan_duty_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_cts_status: assert property ( // [RULE_01]
    ##3 !gp1_sel_i[*3] |-> hs_status_o[0][4] == !$past(mdm_i[0].cts_n, 3))
    else $error("cts status bit mismatch");
  a_dsr_low: assert property ( // [RULE_02]
    mdm_i[0].dsr_n[*4] |-> ##0 !hs_status_o[0][5] || $past(!resetn_i, 3))
    else $error("dsr high seen as ready");
  // the edge that releases reset still shows reset levels, hence resetn_i
  a_rts_drive: assert property ( // [RULE_03]
    resetn_i && core_i[0].rts |=> !request_send_n_o[0])
    else $error("rts not driven low");
  a_dtr_drive: assert property ( // [RULE_04]
    resetn_i && !core_i[0].dtr |=> terminal_ready_n_o[0])
    else $error("dtr not high when idle");
  a_dcd_low: assert property ( // [RULE_05]
    ##3 1'b1 |-> hs_status_o[0][7] == !$past(mdm_i[0].dcd_n, 3))
    else $error("dcd polarity wrong");
  a_sin_path: assert property ( // [RULE_06]
    ##3 1'b1 |-> core_sin_o[0] == $past(mdm_i[0].sin, 3))
    else $error("serial input lost");
  a_sout_path: assert property ( // [RULE_07]
    resetn_i |=> serial_out_o[0] == $past(core_i[0].sout))
    else $error("serial output lost");
  a_cfg_addr: assert property ( // [RULE_08]
    strap_take && !cfg_wr_i |=> cfg_addr_bit == $past(strap_s2_r.cfg_port)
      ##1 cfg_port_o == (cfg_addr_bit ? sppin_pkg::CFG_PORT_HI
      : sppin_pkg::CFG_PORT_LO))
    else $error("config address strap wrong");
  a_strap_hold: assert property ( // [RULE_14]
    !strap_take && !cfg_wr_i |=> $stable(cfg_reg_24_r) && $stable(fan_full_r))
    else $error("strap value moved");
  a_gp1_cts: assert property ( // [RULE_13]
    ##3 gp1_sel_i[*2] |->
      gp1_in_o[sppin_pkg::GP1_CTS_BIT] == $past(mdm_i[1].cts_n, 3))
    else $error("gpio bit 7 not cts");

  c_strap_high: cover property (strap_take && strap_s2_r.cfg_port);
  c_gp1_mode: cover property (gp1_sel_i ##1 !gp1_sel_i);
  c_rts_toggle: cover property (!request_send_n_o[0] ##1 request_send_n_o[0]);
  c_sw_write: cover property (
    cfg_wr_i ##1 cfg_reg_24_r[sppin_pkg::KEYBOARD_EN_BIT]);

endmodule

// File: tb/sppin_modem.sv
// modem model standing on the far side of one serial channel
`timescale 1ns/1ps
module sppin_modem (
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire logic [2:0] line_i,
  input wire logic request_send_n_i,
  output sppin_pkg::sppin_mdm_in_t mdm_o
);
  logic rts_d_r = 1'b1;
  initial mdm_o = '1;
  // clear to send echoes request to send, one edge later when slow;
  // line_i is {carrier, ready, rx data}, the handshake pins are active low
  always @(posedge clk_sys_i) begin
    rts_d_r <= request_send_n_i;
    mdm_o.cts_n <= slow_i ? rts_d_r : request_send_n_i;
    mdm_o.dsr_n <= ~line_i[1];
    mdm_o.dcd_n <= ~line_i[2];
    mdm_o.sin <= line_i[0];
  end
endmodule

// File: tb/sppin_top_tb.sv
// self-checking bench for the serial pin and strap block
`timescale 1ns/1ps
module sppin_top_tb;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  sppin_pkg::sppin_strap_t strap = '0;
  sppin_pkg::sppin_strap_t st_l = '0;
  wire sppin_pkg::sppin_mdm_in_t [5:0] mdm;
  sppin_pkg::sppin_core_out_t [5:0] core = '0;
  logic [5:0][2:0] line = '0;
  logic [5:0] slow = '0;
  logic ir_in = 1'b0, ir_sel = 1'b0, ir_tx = 1'b0, gp1_sel = 1'b0;
  logic cfg_wr = 1'b0, beep = 1'b0, led = 1'b0;
  logic [1:0] gpo = '0;
  logic [7:0] gp1_out = '0, gp1_oe_n = '1, wd26 = '0, wd24 = '0;
  logic [5:0][7:0] hs;
  logic [5:0] sin, rts_n, dtr_n, sout;
  logic ir_out;
  logic [7:0] gp1_in, oe_n, cfg26, cfg24, port;
  logic [6:0] fan;
  logic [1:0] shared;
  integer seed = 32'ha48b72cc;
  logic [31:0] r;
  int fail_count = 0;
  int comparisons = 0;

  initial forever #20 clk_sys_i = ~clk_sys_i;

  sppin_top #(.NCH(6)) i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .strap_i(strap), .mdm_i(mdm), .core_i(core),
    .infrared_receive_in_i(ir_in), .ir_sel_i(ir_sel), .ir_tx_i(ir_tx),
    .gp1_sel_i(gp1_sel), .gp1_out_i(gp1_out), .gp1_oe_n_i(gp1_oe_n),
    .cfg_wr_i(cfg_wr), .cfg_reg_26_wdata_i(wd26),
    .cfg_reg_24_wdata_i(wd24),
    .beep_i(beep), .led_i(led), .gpo_i(gpo), .hs_status_o(hs),
    .core_sin_o(sin), .request_send_n_o(rts_n),
    .terminal_ready_n_o(dtr_n), .serial_out_o(sout),
    .infrared_transmit_out_o(ir_out), .gp1_in_o(gp1_in),
    .gp1_pin_oe_n_o(oe_n), .global_config_reg_26_o(cfg26),
    .global_config_reg_24_o(cfg24), .cfg_port_o(port), .fan_duty_o(fan),
    .shared_pin_o(shared));

  // one modem per channel, each fed back from its own request pin
  for (genvar g = 0; g < 6; g++) begin : g_mdm
    sppin_modem i_mdm (.clk_sys_i(clk_sys_i), .slow_i(slow[g]),
      .line_i(line[g]), .request_send_n_i(rts_n[g]), .mdm_o(mdm[g]));
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // pin levels of a channel, {rts_n, dtr_n, sout}
  function automatic logic [2:0] pin_exp(int c);
    if (c == 1 && gp1_sel)
      return {gp1_out[5], gp1_out[4], gp1_out[2]};
    return {~core[c].rts, ~core[c].dtr, core[c].sout};
  endfunction

  function automatic logic sin_exp(int c);
    if (c == 1 && ir_sel)
      return ir_in;
    if (c == 1 && gp1_sel)
      return 1'b1;
    return line[c][0];
  endfunction

  task automatic cfg_check(logic [7:0] a26, logic [7:0] a24);
    check("cfg26", cfg26, a26);
    check("port", port, a26[6] ? 8'h4e : 8'h2e);
    check("floppy", cfg24[1], a24[1]);
    check("keyboard", cfg24[2], a24[2]);
    check("cfg24", cfg24, a24);
  endtask

  // straps held across reset, then wiggled after capture; with wr set a
  // write lands on the capture edge and has to lose against the straps
  task automatic do_reset(logic [4:0] s, logic wr);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk_sys_i);
    r = $random(seed);
    resetn_i <= 1'b1;
    cfg_wr <= wr;
    {wd26, wd24} <= r[15:0];
    st_l = s;
    @(posedge clk_sys_i);
    cfg_wr <= 1'b0;
    @(posedge clk_sys_i);
    strap <= r[20:16];
    repeat (4) @(negedge clk_sys_i);
    cfg_check({1'b0, st_l.cfg_port, 6'h0}, {5'h0, st_l.keyboard_en,
      st_l.floppy_uart, 1'b0});
    check("fan", fan, st_l.fan_full ? 7'h64 : 7'h32);
  endtask

  task automatic drive_pins();
    for (int c = 0; c < 6; c++) begin
      r = $random(seed);
      core[c] <= r[2:0];
      line[c] <= r[5:3];
      slow[c] <= r[6];
    end
    r = $random(seed);
    gp1_sel <= r[1:0] == 2'h1;
    ir_sel <= r[1:0] == 2'h2;
    {gpo, led, beep, ir_tx, ir_in} <= r[7:2];
    {gp1_oe_n, gp1_out} <= r[23:8];
  endtask

  // modem echo adds up to two edges to the three of the status path
  task automatic pin_round();
    logic [2:0] p;
    logic b;
    for (int c = 0; c < 6; c++) begin
      p = pin_exp(c);
      // status of a channel whose pins are borrowed by gpio reads zero
      b = c == 1 && gp1_sel;
      check("rts", rts_n[c], p[2]);
      check("dtr", dtr_n[c], p[1]);
      check("sout", sout[c], p[0]);
      check("sin", sin[c], sin_exp(c));
      check("cts", hs[c][sppin_pkg::MSR_CTS_BIT], b ? 1'b0 : !p[2]);
      check("dsr", hs[c][sppin_pkg::MSR_DSR_BIT], b ? 1'b0 : line[c][1]);
      check("dcd", hs[c][sppin_pkg::MSR_DCD_BIT], b ? 1'b0 : line[c][2]);
    end
    check("infrared_transmit_out", ir_out, ir_sel & ir_tx);
    check("oe", oe_n, gp1_sel ? gp1_oe_n | 8'hcb : 8'hff);
    if (gp1_sel)
      check("gp1", gp1_in, {gp1_out[5], ~line[1][1], gp1_out[5], gp1_out[4],
        line[1][0], gp1_out[2], ~line[1][2], 1'b1});
    check("shr", shared, st_l.pin_func ? gpo : {led, beep});
  endtask

  ////////////////////////////////////////////////////////////////////
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    tally_and_finish();
  end

  // strap corners first, then random straps, pins and config writes
  initial begin
    for (int n = 0; n < 8; n++) begin
      r = $random(seed);
      do_reset(n == 0 ? 5'h00 : n == 1 ? 5'h1f : r[4:0], n[0]);
      for (int k = 0; k < 10; k++) begin
        @(posedge clk_sys_i);
        drive_pins();
        repeat (8) @(negedge clk_sys_i);
        pin_round();
      end
      @(posedge clk_sys_i);
      r = $random(seed);
      cfg_wr <= 1'b1;
      {wd26, wd24} <= r[15:0];
      @(posedge clk_sys_i);
      cfg_wr <= 1'b0;
      repeat (2) @(negedge clk_sys_i);
      cfg_check(wd26, wd24);
    end
    tally_and_finish();
  end
endmodule
